//--- verilog/pisr_top.sv
// Package idle state resolver with AXI4-Lite configuration.
`timescale 1ns/10ps
`default_nettype none
module pisr_top
  import pisr_pkg::*;
#(
  parameter int unsigned RES_THRESH = RES_THRESH_DEF,
  parameter int unsigned REEN_DELAY = REEN_DELAY_DEF
)
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core idle requests.
  input wire logic [NCORE-1:0][2:0] core_req,
  input wire logic [NCORE-1:0] core_c1e_hint,
  input wire logic [NCORE-1:0] core_halt,
  input wire logic [NCORE-1:0] core_flush_hint,
  input wire logic [NCORE-1:0] core_break,
  input wire logic [NCORE-1:0] core_break_mask,
  output logic [NCORE-1:0] core_wake,
  // Platform side, asynchronous inputs.
  input wire logic [2:0] plat_grant,
  input wire logic plat_wake,
  input wire logic plat_hold,
  output logic plat_notify,
  // Package state and power actions.
  output logic [2:0] pkg_level,
  output logic pkg_servicing,
  output logic clk_low,
  output logic volt_low,
  output logic [WAYS_W-1:0] cache_ways
);

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------

  // Level code reported for a package state.
  function automatic logic [2:0] st_code(input pisr_state_e s);
    unique case (s)
      ST_C1: st_code = LVL_C1;
      ST_C1E: st_code = LVL_C1E;
      ST_C3: st_code = LVL_C3;
      ST_C6: st_code = LVL_C6;
      ST_C7: st_code = LVL_C7;
      default: st_code = LVL_C0;
    endcase
  endfunction

  // Unused core codes fall to the next shallower level.
  function automatic pisr_state_e lvl_to_st(input logic [2:0] lvl);
    if (lvl >= LVL_C7) lvl_to_st = ST_C7;
    else if (lvl >= LVL_C6) lvl_to_st = ST_C6;
    else if (lvl >= LVL_C3) lvl_to_st = ST_C3;
    else if (lvl == LVL_C1E) lvl_to_st = ST_C1E;
    else if (lvl == LVL_C1) lvl_to_st = ST_C1;
    else lvl_to_st = ST_C0;
  endfunction

  // Demotion of one core request.
  function automatic logic [2:0] demote(input logic [2:0] req, input logic credit,
                                        input logic d3, input logic d1);
    demote = req;
    // R1 R2: two options, credit lifts both.
    if (!credit && d1 && req >= LVL_C3) demote = LVL_C1;
    else if (!credit && d3 && req >= LVL_C6) demote = LVL_C3;
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == REG_CTRL) || (a == REG_MISC) || (a == REG_STAT);
  endfunction

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  // R24: undocumented figures set from parameters.
  localparam logic [CNT_W-1:0] RES_C = CNT_W'(RES_THRESH);
  localparam logic [CNT_W-1:0] REEN_C = CNT_W'(REEN_DELAY);
  localparam logic [5:0] SETTLE_C = 6'(C1E_SETTLE_CYC);

  logic [PLAT_W-1:0] plat_raw, plat_s1, plat_s2, plat_s3, plat_q;
  logic [2:0] plat_grant_q;
  logic plat_wake_q, plat_hold_q;
  logic cfg_d3, cfg_d1, cfg_c1e, misc_promo;
  logic [2:0] cfg_limit;
  logic [NCORE-1:0][CNT_W-1:0] run_cnt;
  logic [NCORE-1:0] credit, break_hold, req_c0, brk_set;
  logic [NCORE-1:0][2:0] eff_lvl;
  logic [2:0] req_min, lim_lvl, base_lvl, tgt_lvl;
  logic all_hint, all_halt, any_flush, use_c1e;
  pisr_state_e st, prev_st, next_st, tgt_st, ret_st;
  logic svc_enter, shrink_go, shrinking, deep_st, cache_off;
  logic [WAYS_W-1:0] step;
  logic [1:0] entry_cnt;
  logic [CNT_W-1:0] out_cnt;
  logic [5:0] settle;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data, ctrl_word, misc_word, stat_word, rd_word;
  logic wr_lane0, do_write;

  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Platform input synchroniser.
  // ----------------------------------------------------------------

  // A change counts only once the second and third stages agree.
  assign plat_raw = {plat_hold, plat_wake, plat_grant};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      plat_s1 <= '0;
      plat_s2 <= '0;
      plat_s3 <= '0;
      plat_q <= '0;
    end
    else
    begin
      plat_s1 <= plat_raw;
      plat_s2 <= plat_s1;
      plat_s3 <= plat_s2;
      if (plat_s2 == plat_s3) plat_q <= plat_s3;
    end
  end
  assign plat_grant_q = plat_q[2:0];
  assign plat_wake_q = plat_q[3];
  assign plat_hold_q = plat_q[4];

  // ----------------------------------------------------------------
  // Per-core residency history, demotion and break handling.
  // ----------------------------------------------------------------

  // Credit comes from the length of the last idle run.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_cnt <= '0;
      credit <= '0;
    end
    else
    begin
      for (int i = 0; i < NCORE; i++)
      begin
        if (req_c0[i])
        begin
          run_cnt[i] <= '0;
          if (run_cnt[i] != '0) credit[i] <= (run_cnt[i] >= RES_C);
        end
        else if (run_cnt[i] != '1) run_cnt[i] <= run_cnt[i] + 1'b1;
      end
    end
  end

  // Break hold keeps a core woken by an unmasked break at C0 until it asks for C0 itself.
  for (genvar g = 0; g < NCORE; g++)
  begin : g_core
    assign req_c0[g] = (core_req[g] == LVL_C0);
    // R2: demoted request from history.
    assign eff_lvl[g] = break_hold[g] ? LVL_C0 : demote(core_req[g], credit[g], cfg_d3, cfg_d1);
  end
  assign brk_set = core_break & ~core_break_mask;

  // R7: forward the event; an unmasked one forces C0, set beats release.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      break_hold <= '0;
      core_wake <= '0;
    end
    else
    begin
      break_hold <= (break_hold & ~req_c0) | brk_set;
      core_wake <= core_break;
    end
  end

  // ----------------------------------------------------------------
  // Package level resolution.
  // ----------------------------------------------------------------

  // R4: shallowest effective core level wins.
  always_comb
  begin
    req_min = LVL_C7;
    all_hint = 1'b1;
    all_halt = 1'b1;
    any_flush = 1'b0;
    for (int i = 0; i < NCORE; i++)
    begin
      if (eff_lvl[i] < req_min) req_min = eff_lvl[i];
      all_hint = all_hint & core_c1e_hint[i];
      all_halt = all_halt & core_halt[i];
      any_flush = any_flush | (core_flush_hint[i] & (core_req[i] == LVL_C7));
    end
  end

  // R5 R11 R16 R17: platform grant and configured limit cap the level.
  assign lim_lvl = (plat_grant_q < cfg_limit) ? plat_grant_q : cfg_limit;
  // R13: C1 when the shallowest core sits at C1.
  assign base_lvl = (req_min < lim_lvl) ? req_min : lim_lvl;
  // R10 R14: C1E by enable, hint, limit or auto-promotion.
  assign use_c1e = (base_lvl == LVL_C1) && (cfg_c1e || all_hint
                   || ((cfg_limit == LVL_C1) && (req_min > LVL_C1)) || (all_halt && misc_promo));
  assign tgt_lvl = use_c1e ? LVL_C1E : base_lvl;
  // R18 R19: hold C6 until every cache way is gone.
  assign tgt_st = ((lvl_to_st(tgt_lvl) == ST_C7) && (cache_ways != '0)) ? ST_C6
                  : lvl_to_st(tgt_lvl);

  // ----------------------------------------------------------------
  // Package state machine.
  // ----------------------------------------------------------------

  // R20: a wake taken in C7 can only be a memory access, never a snoop.
  assign svc_enter = plat_wake_q && (st == ST_C3 || st == ST_C6 || st == ST_C7);
  assign ret_st = (st_code(prev_st) < st_code(tgt_st)) ? prev_st : tgt_st;

  // R6: idle levels move straight to the target without C0.
  always_comb
  begin
    next_st = tgt_st;
    unique case (st)
      ST_SVC:
      begin
        // R8 R9: return to the earlier level, or to a shallower target, unless the platform holds.
        if (plat_wake_q) next_st = ST_SVC;
        else if (plat_hold_q) next_st = tgt_st;
        else next_st = ret_st;
      end
      default:
      begin
        if (svc_enter) next_st = ST_SVC;
      end
    endcase
  end

  // Outputs follow the next state so they line up with st.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= ST_C0;
      prev_st <= ST_C0;
      pkg_level <= LVL_C0;
      pkg_servicing <= 1'b0;
      plat_notify <= 1'b0;
    end
    else
    begin
      st <= next_st;
      if (svc_enter) prev_st <= st;
      pkg_level <= st_code(next_st);
      pkg_servicing <= (next_st == ST_SVC);
      // R15: only C3 and deeper are announced.
      plat_notify <= (st_code(next_st) >= LVL_C3);
    end
  end

  // ----------------------------------------------------------------
  // Shared cache sizing.
  // ----------------------------------------------------------------
  assign shrink_go = (st == ST_C6) && (lvl_to_st(tgt_lvl) == ST_C7);
  assign deep_st = (st == ST_C6) || (st == ST_C7) || (st == ST_SVC);

  // Growing back slowly avoids refilling a cache that is soon flushed.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cache_ways <= L3_WAYS;
      step <= 4'h1;
      entry_cnt <= 2'h0;
      shrinking <= 1'b0;
      cache_off <= 1'b0;
      out_cnt <= '0;
    end
    else
    begin
      shrinking <= shrink_go;
      // R22: fresh step size on each C7 entry.
      if (shrink_go && !shrinking)
      begin
        step <= WAYS_W'(entry_cnt) + 4'h1;
        entry_cnt <= entry_cnt + 2'h1;
      end
      // R23: flush hint drops every way at once.
      if (shrink_go && any_flush) cache_ways <= '0;
      // R19: shrink by the chosen step.
      else if (shrink_go && shrinking) cache_ways <= (cache_ways > step) ? cache_ways - step : '0;
      else if (!deep_st && !cache_off && cache_ways < L3_WAYS) cache_ways <= cache_ways + 4'h1;
      // R21: stay off until out of C6, C7 and service long enough.
      if (deep_st) out_cnt <= '0;
      else if (cache_off) out_cnt <= out_cnt + 1'b1;
      if (st == ST_C7) cache_off <= 1'b1;
      else if (!deep_st && out_cnt >= REEN_C) cache_off <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // C1E clock and voltage sequence.
  // ----------------------------------------------------------------

  // R12: clock drops first, voltage after the settle time.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_low <= 1'b0;
      volt_low <= 1'b0;
      settle <= '0;
    end
    else if (st == ST_C1E)
    begin
      clk_low <= 1'b1;
      if (!clk_low) settle <= '0;
      else if (settle != SETTLE_C) settle <= settle + 6'h1;
      else volt_low <= 1'b1;
    end
    else
    begin
      // Voltage comes back before the clock speeds up.
      settle <= '0;
      volt_low <= 1'b0;
      if (!volt_low) clk_low <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave.
  // ----------------------------------------------------------------
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // One write in flight; address and data may come in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_lane0 <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_lane0 <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // R3: demotion options off at reset, each with its own bit.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_d3 <= 1'b0;
      cfg_d1 <= 1'b0;
      cfg_c1e <= 1'b0;
      cfg_limit <= CTRL_LIM_RST;
      misc_promo <= 1'b0;
    end
    else if (do_write && wr_lane0)
    begin
      if (wr_addr == REG_CTRL)
      begin
        cfg_d3 <= wr_data[CTRL_DEM_C3_BIT];
        cfg_d1 <= wr_data[CTRL_DEM_C1_BIT];
        cfg_c1e <= wr_data[CTRL_C1E_BIT];
        cfg_limit <= wr_data[CTRL_LIM_LSB +: 3];
      end
      if (wr_addr == REG_MISC) misc_promo <= wr_data[MISC_PROMO_BIT];
    end
  end

  // Read words; unused bits read as zero.
  always_comb
  begin
    ctrl_word = 32'h0;
    ctrl_word[CTRL_DEM_C3_BIT] = cfg_d3;
    ctrl_word[CTRL_DEM_C1_BIT] = cfg_d1;
    ctrl_word[CTRL_C1E_BIT] = cfg_c1e;
    ctrl_word[CTRL_LIM_LSB +: 3] = cfg_limit;
    misc_word = 32'h0;
    misc_word[MISC_PROMO_BIT] = misc_promo;
    stat_word = 32'h0;
    stat_word[STAT_LVL_LSB +: 3] = pkg_level;
    stat_word[STAT_WAYS_LSB +: WAYS_W] = cache_ways;
    stat_word[STAT_SVC_BIT] = pkg_servicing;
    stat_word[STAT_CLK_BIT] = clk_low;
    stat_word[STAT_VOLT_BIT] = volt_low;
    stat_word[STAT_OFF_BIT] = cache_off;
    stat_word[STAT_CRED_LSB +: NCORE] = credit;
  end
  assign rd_word = (s_axi_araddr == REG_CTRL) ? ctrl_word
                 : (s_axi_araddr == REG_MISC) ? misc_word
                 : (s_axi_araddr == REG_STAT) ? stat_word : 32'h0;

  // Read data is answered the cycle after the address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  sequence s_clk_drop;
    $rose(clk_low);
  endsequence
  sequence s_volt_held;
    !volt_low [*8];
  endsequence
  sequence s_svc_done;
    st == ST_SVC && !plat_wake_q && !plat_hold_q;
  endsequence

  // R3 requests pass unchanged.
  plain_pass_a: assert property ((!cfg_d3 && !cfg_d1 && !break_hold[0]) |-> eff_lvl[0] == core_req[0]) // R3
    else $error("Request altered while demotion is off.");
  // R1 demotion to C1.
  demote_c1_a: assert property ((cfg_d1 && core_req[0] >= LVL_C3 && !credit[0] && !break_hold[0]) |-> eff_lvl[0] == LVL_C1) // R1
    else $error("Missing demotion to C1.");
  // R2 demotion to C3.
  demote_c3_a: assert property ((cfg_d3 && !cfg_d1 && core_req[0] >= LVL_C6 && !credit[0] && !break_hold[0]) |-> eff_lvl[0] == LVL_C3) // R2
    else $error("Missing demotion to C3.");
  // R4 level bounded by cores.
  pkg_min_a: assert property (base_lvl <= req_min && base_lvl <= plat_grant_q) // R4
    else $error("Package level deeper than allowed.");
  // R11 active keeps C0.
  busy_active_a: assert property (((req_min == LVL_C0) || (plat_grant_q == LVL_C0)) && !plat_wake_q |=> st == ST_C0) // R11
    else $error("Package left C0 while busy.");
  // R10 C1E replaces C1.
  c1e_pick_a: assert property ((base_lvl == LVL_C1 && cfg_c1e) |-> tgt_lvl == LVL_C1E) // R10
    else $error("C1E not chosen.");
  // R12 clock before voltage.
  c1e_order_a: assert property (s_clk_drop |-> s_volt_held) // R12
    else $error("Voltage dropped too early.");
  // R15 no notice in C1.
  quiet_c1_a: assert property ((st == ST_C1 || st == ST_C1E) |-> !plat_notify) // R15
    else $error("Notice raised in C1 or C1E.");
  // R19 empty cache in C7.
  c7_empty_a: assert property (st == ST_C7 |-> cache_ways == '0) // R19
    else $error("C7 with cache ways left.");
  // R23 one step flush.
  flush_step_a: assert property ((shrink_go && any_flush) |=> cache_ways == '0) // R23
    else $error("Flush hint did not empty cache.");
  // R21 cache held off.
  reen_wait_a: assert property ((cache_off && !deep_st) |=> cache_ways == '0) // R21
    else $error("Cache grew while held off.");
  // R7 break wakes core.
  break_wake_a: assert property ((core_break[0] && !core_break_mask[0]) |=> core_wake[0] && break_hold[0]) // R7
    else $error("Break event not forwarded.");
  // R8 return after service.
  svc_return_a: assert property ((s_svc_done ##0 st_code(prev_st) <= st_code(tgt_st)) |=> st == $past(prev_st)) // R8
    else $error("No return to earlier level.");

endmodule // pisr_top
`default_nettype wire

//--- include/pisr_pkg.sv
// Constants and types for the package idle state resolver.
//
// What this block does
// R1: Two demotion options: deep to C3, to C1.
// R2: Demote until residency history gives credit.
// R3: Demotion off at reset, options enabled separately.
// R4: Package request is the shallowest core level.
// R5: Deeper package level needs platform permission.
// R6: Direct moves between idle levels allowed.
// R7: Core break wakes core; unmasked forces C0.
// R8: Memory or snoop wake returns to previous level.
// R9: Platform hold keeps shallower level after wake.
// R10: C1E replaces C1 when C1E enabled.
// R11: Busy core or no permission keeps C0.
// R12: C1E lowers clock first, then voltage.
// R13: C1 when shallowest core is C1.
// R14: Three C1E cases: hint, limit, auto-promotion.
// R15: No system signal on C1 or C1E.
// R16: C3 by resolution or platform limit; cache valid.
// R17: C6 by resolution or platform limit.
// R18: Stay in C6 while cache ways remain.
// R19: C7 only when all C7, cache empty.
// R20: Platform sends no snoops in C7.
// R21: Cache stays off for delay after C7.
// R22: Shrink step size chosen per C7 entry.
// R23: Flush hint empties cache in one step.
// R24: Residency threshold and re-enable delay are parameters.
package pisr_pkg;
  // ----------------------------------------------------------------
  // Sizes and level codes.
  // ----------------------------------------------------------------
  localparam int NCORE = 2;
  localparam int CNT_W = 16;
  localparam int WAYS_W = 4;
  localparam int ADDR_W = 8;
  localparam int PLAT_W = 5;
  localparam logic [WAYS_W-1:0] L3_WAYS = 4'hC;
  localparam logic [2:0] LVL_C0 = 3'h0;
  localparam logic [2:0] LVL_C1 = 3'h1;
  localparam logic [2:0] LVL_C1E = 3'h2;
  localparam logic [2:0] LVL_C3 = 3'h3;
  localparam logic [2:0] LVL_C6 = 3'h6;
  localparam logic [2:0] LVL_C7 = 3'h7;
  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int C1E_SETTLE_NS = 1000;
  localparam int C1E_SETTLE_CYC = (C1E_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RES_THRESH_DEF = 1000;
  localparam int REEN_DELAY_DEF = 8000;
  // ----------------------------------------------------------------
  // Register map and fields.
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MISC = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h08;
  localparam int CTRL_DEM_C3_BIT = 0;
  localparam int CTRL_DEM_C1_BIT = 1;
  localparam int CTRL_C1E_BIT = 2;
  localparam int CTRL_LIM_LSB = 4;
  localparam logic [2:0] CTRL_LIM_RST = 3'h7;
  localparam int MISC_PROMO_BIT = 0;
  localparam int STAT_LVL_LSB = 0;
  localparam int STAT_WAYS_LSB = 4;
  localparam int STAT_SVC_BIT = 8;
  localparam int STAT_CLK_BIT = 9;
  localparam int STAT_VOLT_BIT = 10;
  localparam int STAT_OFF_BIT = 11;
  localparam int STAT_CRED_LSB = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Package state machine.
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_C0, ST_C1, ST_C1E, ST_C3, ST_C6, ST_C7, ST_SVC} pisr_state_e;
endpackage

//--- verif/pisr_plat_model.sv
// Platform controller model that grants package levels and sends wakes.
`timescale 1ns/10ps
`default_nettype none
module pisr_plat_model
  import pisr_pkg::*;
(
  // Clock and bench commands.
  input wire logic aclk,
  input wire logic [2:0] want_grant,
  input wire logic want_wake,
  input wire logic want_hold,
  // Device side.
  input wire logic [2:0] pkg_level,
  output logic [2:0] plat_grant,
  output logic plat_wake,
  output logic plat_hold
);
  // Outputs start at no grant and no wake.
  initial {plat_grant, plat_wake, plat_hold} = 5'h00;
  always @(posedge aclk)
  begin
    plat_grant <= want_grant;
    plat_hold <= want_hold;
    plat_wake <= want_wake && (pkg_level != LVL_C7); // A package level of C7 means nothing to snoop.
  end
endmodule // pisr_plat_model
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the package idle state resolver.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pisr_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, svc, clk_low, volt_low, notify;
  logic [1:0] bresp, rresp, wake;
  logic [31:0] rdata;
  logic [NCORE-1:0][2:0] req = 0;
  logic [1:0] hint = 0, halt = 0, flush = 0, brk = 0, bmask = 0;
  logic [2:0] grant = 7, lvl, pg;
  logic pw, ph, wk = 0, hold = 0;
  logic [3:0] ways;
  int failures = 0, cmp_count = 0, cyc = 0;
  pisr_top #(.RES_THRESH(8), .REEN_DELAY(10)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_req(req), .core_c1e_hint(hint), .core_halt(halt), .core_flush_hint(flush),
    .core_break(brk), .core_break_mask(bmask), .core_wake(wake), .plat_grant(pg),
    .plat_wake(pw), .plat_hold(ph), .plat_notify(notify), .pkg_level(lvl),
    .pkg_servicing(svc), .clk_low(clk_low), .volt_low(volt_low), .cache_ways(ways));
  pisr_plat_model plat_u (.aclk(aclk), .want_grant(grant), .want_wake(wk),
    .want_hold(hold), .pkg_level(lvl), .plat_grant(pg), .plat_wake(pw), .plat_hold(ph));
  // 40 MHz clock.
  initial forever #12.5 aclk = ~aclk;
  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // The ceiling is far above the few hundred cycles the tests need.
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Address and data are offered together and each is released when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (awready && !ad) begin ad = 1; awvalid <= 0; end
      if (wready && !wd) begin wd = 1; wvalid <= 0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 0;
    chk("bresp", er, bresp);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
    chk("rdata", e, rdata);
    chk("rresp", er, rresp);
  endtask
  // Waits, bounded, for the package level and then compares it.
  task automatic wl(input logic [2:0] e);
    for (int i = 0; i < 300 && lvl !== e; i++) @(posedge aclk);
    chk("pkg_level", e, lvl);
  endtask
  task automatic cores(input logic [2:0] a, input logic [2:0] b);
    @(posedge aclk);
    req <= {b, a};
  endtask
  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_regs();
    axi_rd(REG_CTRL, 32'h00000070, RESP_OKAY);
    axi_rd(REG_STAT, 32'h000000C0, RESP_OKAY);
    axi_rd(8'h0C, 32'h00000000, RESP_SLVERR);
    axi_wr(8'h10, 32'h00000007, RESP_SLVERR);
    $display("t_regs done");
  endtask
  task automatic t_demote();
    cores(LVL_C6, LVL_C6);
    wl(LVL_C6);
    axi_wr(REG_CTRL, 32'h00000071, RESP_OKAY);
    wl(LVL_C3);
    axi_wr(REG_CTRL, 32'h00000072, RESP_OKAY);
    wl(LVL_C1);
    axi_wr(REG_CTRL, 32'h00000070, RESP_OKAY);
    cores(LVL_C0, LVL_C0);
    wl(LVL_C0);
    $display("t_demote done");
  endtask
  task automatic t_c1e();
    cores(LVL_C1, LVL_C3);
    wl(LVL_C1);
    chk("notify", 0, notify);
    axi_wr(REG_CTRL, 32'h00000074, RESP_OKAY);
    wl(LVL_C1E);
    repeat (45) @(posedge aclk);
    chk("clk_low", 1, clk_low);
    chk("volt_low", 1, volt_low);
    cores(LVL_C0, LVL_C3);
    wl(LVL_C0);
    axi_wr(REG_CTRL, 32'h00000070, RESP_OKAY);
    hint <= 2'h3;
    cores(LVL_C1, LVL_C1);
    wl(LVL_C1E);
    hint <= 2'h0;
    halt <= 2'h3;
    wl(LVL_C1);
    axi_wr(REG_MISC, 32'h00000001, RESP_OKAY);
    wl(LVL_C1E);
    halt <= 2'h0;
    axi_wr(REG_CTRL, 32'h00000010, RESP_OKAY);
    cores(LVL_C3, LVL_C6);
    wl(LVL_C1E);
    axi_wr(REG_CTRL, 32'h00000070, RESP_OKAY);
    axi_wr(REG_MISC, 32'h00000000, RESP_OKAY);
    $display("t_c1e done");
  endtask
  task automatic t_resolve();
    cores(LVL_C3, LVL_C6);
    wl(LVL_C3);
    chk("notify", 1, notify);
    cores(LVL_C6, LVL_C6);
    wl(LVL_C6);
    grant <= LVL_C3;
    wl(LVL_C3);
    grant <= LVL_C0;
    wl(LVL_C0);
    grant <= LVL_C7;
    wk <= 1;
    wl(LVL_C6);
    repeat (8) @(posedge aclk);
    chk("servicing", 1, svc);
    wk <= 0;
    wl(LVL_C6);
    wk <= 1;
    repeat (8) @(posedge aclk);
    grant <= LVL_C1; hold <= 1; wk <= 0;
    wl(LVL_C1);
    grant <= LVL_C7; hold <= 0;
    $display("t_resolve done");
  endtask
  task automatic t_c7();
    cores(LVL_C7, LVL_C7);
    wl(LVL_C7);
    chk("ways", 0, ways);
    @(posedge aclk);
    brk <= 2'h1;
    @(posedge aclk);
    brk <= 2'h0;
    @(posedge aclk);
    chk("core_wake", 2'h1, wake);
    wl(LVL_C0);
    cores(LVL_C0, LVL_C7);
    repeat (6) @(posedge aclk);
    chk("ways", 0, ways);
    for (int i = 0; i < 300 && ways !== L3_WAYS; i++) @(posedge aclk);
    chk("ways", L3_WAYS, ways);
    flush <= 2'h3;
    cores(LVL_C7, LVL_C7);
    wl(LVL_C6);
    @(posedge aclk);
    chk("ways", 0, ways);
    wl(LVL_C7);
    $display("t_c7 done");
  endtask
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    t_regs();
    t_demote();
    t_c1e();
    t_resolve();
    t_c7();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
